// file: src/ipeme_device.sv
// Interrupt controller end: priorities, edge detection, shared source and master enable.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ipeme_device #(
    parameter int PORTC = 4
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Processor link
    ipeme_if.dev            bus,
    // Interrupt sources
    input  wire logic [7:0] pin_in,
    input  wire logic       comparator_in,
    input  wire logic [3:0] portc_in
);

    // ********************************************************************
    // Parameter check
    // ********************************************************************
    if (PORTC < 1 || PORTC > 4) begin : g_chk
        $error("PORTC must lie between 1 and 4.");
    end

    // ********************************************************************
    // State
    // ********************************************************************
    logic [3:0]  prio_high;
    logic [3:0]  prio_low;
    logic [7:0]  edge_sel;
    logic        share_sel;
    logic        master;
    logic [7:0]  pin_prev;
    logic [7:0]  pin_pend;
    logic [3:0]  pc_prev;
    logic [3:0]  pc_pend;
    logic [7:0]  rdata;
    logic        req;
    logic [3:0]  req_src;
    logic [1:0]  req_level;
    logic [3:0]  next_prio_high;
    logic [3:0]  next_prio_low;
    logic [7:0]  next_edge_sel;
    logic        next_share_sel;
    logic        next_master;
    logic [7:0]  next_pin_prev;
    logic [7:0]  next_pin_pend;
    logic [3:0]  next_pc_prev;
    logic [3:0]  next_pc_pend;
    logic [7:0]  next_rdata;
    logic        next_req;
    logic [3:0]  next_req_src;
    logic [1:0]  next_req_level;
    logic [7:0]  pin_src;
    logic [7:0]  pin_evt;
    logic [3:0]  pc_evt;
    logic [3:0]  pc_mask;
    logic [4:0]  pick;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic wr_hit(input logic [11:0] ofs);
        wr_hit = bus.wr && (bus.addr == ofs);
    endfunction

    // Returns {valid, index, level}; the highest level wins, the lower index on a tie.
    function automatic logic [4:0] arbitrate(input logic [3:0] pend,
                                             input logic [3:0] hi,
                                             input logic [3:0] lo);
        logic [1:0] code;
        logic [1:0] best;
        logic [1:0] idx;
        logic       found;
        best  = ipeme_pkg::PRIO_OFF;
        idx   = 2'h0;
        found = 1'b0;
        for (int i = 0; i < 4; i++) begin
            code = {hi[i], lo[i]};
            if (pend[i] && code != ipeme_pkg::PRIO_OFF && code > best) begin
                best  = code;
                idx   = i[1:0];
                found = 1'b1;
            end
        end
        arbitrate = {found, idx, best};
    endfunction

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        next_prio_high = prio_high;
        next_prio_low  = prio_low;
        next_edge_sel  = edge_sel;
        next_share_sel = share_sel;
        // Only the low nibble of the priority registers is kept; their reserved upper bits read zero.
        if (wr_hit(ipeme_pkg::OFS_PRIO_HIGH)) begin
            next_prio_high = bus.wdata[3:0];
        end
        if (wr_hit(ipeme_pkg::OFS_PRIO_LOW)) begin
            next_prio_low = bus.wdata[3:0];
        end
        if (wr_hit(ipeme_pkg::OFS_EDGE_SEL)) begin
            next_edge_sel = bus.wdata;
        end
        if (wr_hit(ipeme_pkg::OFS_SHARE_SEL)) begin
            next_share_sel = bus.wdata[ipeme_pkg::SHARE_BIT];
        end

        // Disable and acknowledge win over enable and return, which win over a register write, in the same cycle.
        next_master = master;
        if (wr_hit(ipeme_pkg::OFS_MASTER)) begin
            next_master = bus.wdata[ipeme_pkg::MASTER_BIT];
        end
        if (bus.instr_enable || bus.instr_return) begin
            next_master = 1'b1;
        end
        if (bus.instr_disable || bus.ack) begin
            next_master = 1'b0;
        end
    end

    always_comb begin
        pin_src = pin_in;
        if (share_sel) begin
            pin_src[ipeme_pkg::SHARED_PIN] = comparator_in;
        end
        // A change of source alone can make an edge here and raise a request.
        pin_evt = (edge_sel & pin_src & ~pin_prev) | (~edge_sel & ~pin_src & pin_prev);
        next_pin_prev = pin_src;
        pc_mask = 4'((1 << PORTC) - 1);
        pc_evt  = portc_in & ~pc_prev & pc_mask;
        next_pc_prev = portc_in;

        // A new event in the acknowledge cycle keeps its pending bit.
        next_pin_pend = pin_pend;
        next_pc_pend  = pc_pend;
        if (bus.ack) begin
            if (bus.ack_src[3]) begin
                next_pin_pend[bus.ack_src[2:0]] = 1'b0;
            end else begin
                next_pc_pend[bus.ack_src[1:0]] = 1'b0;
            end
        end
        next_pin_pend = next_pin_pend | pin_evt;
        next_pc_pend  = next_pc_pend | pc_evt;

        pick           = arbitrate(pc_pend, prio_high, prio_low);
        next_req       = master && pick[4];
        next_req_src   = {2'h0, pick[3:2]};
        next_req_level = pick[1:0];
    end

    always_comb begin
        next_rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                ipeme_pkg::OFS_PRIO_HIGH: next_rdata = {4'h0, prio_high};
                ipeme_pkg::OFS_PRIO_LOW:  next_rdata = {4'h0, prio_low};
                ipeme_pkg::OFS_EDGE_SEL:  next_rdata = edge_sel;
                ipeme_pkg::OFS_SHARE_SEL: next_rdata = {1'b0, share_sel, 6'h00};
                ipeme_pkg::OFS_MASTER:    next_rdata = {master, 7'h00};
                default:                  next_rdata = 8'h00;
            endcase
        end
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prio_high <= ipeme_pkg::RST_REG[3:0];
            prio_low  <= ipeme_pkg::RST_REG[3:0];
            edge_sel  <= ipeme_pkg::RST_REG;
            share_sel <= 1'b0;
            master    <= 1'b0;
            pin_prev  <= 8'h00;
            pin_pend  <= 8'h00;
            pc_prev   <= 4'h0;
            pc_pend   <= 4'h0;
            rdata     <= 8'h00;
            req       <= 1'b0;
            req_src   <= 4'h0;
            req_level <= 2'h0;
        end else begin
            prio_high <= next_prio_high;
            prio_low  <= next_prio_low;
            edge_sel  <= next_edge_sel;
            share_sel <= next_share_sel;
            master    <= next_master;
            pin_prev  <= next_pin_prev;
            pin_pend  <= next_pin_pend;
            pc_prev   <= next_pc_prev;
            pc_pend   <= next_pc_pend;
            rdata     <= next_rdata;
            req       <= next_req;
            req_src   <= next_req_src;
            req_level <= next_req_level;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign bus.rdata       = rdata;
    assign bus.req         = req;
    assign bus.req_src     = req_src;
    assign bus.req_level   = req_level;
    assign bus.pin_request = pin_pend & {8{master}};

endmodule
`default_nettype wire

// file: inc/ipeme_pkg.sv
// Shared constants of the interrupt priority, edge select and master enable block.
// Behaviour
// - Enable bit pair encodes priority: off, 1, 2, 3.
// - Bits 3..0 set port C0..C3 priority.
// - Software writes zeros to group-2 upper bits.
// - Edge bit: 0 falling, 1 rising edge.
// - Select bit 6: pin 6 or comparator.
// - Switching shared source may raise a request.
// - Software disables interrupt before switching source.
// - Software writes zero to select reserved bits.
// - Master enable bit 7 gates all interrupts.
// - Enable, return or write-one sets master.
// - Disable, acknowledge, reset or write-zero clears master.
// - Control bits 6..0 read zero, written zero.
package ipeme_pkg;

    // ********************************************************************
    // Device register map and fields
    // ********************************************************************
    localparam logic [11:0] OFS_PRIO_HIGH = 12'hfc7;
    localparam logic [11:0] OFS_PRIO_LOW  = 12'hfc8;
    localparam logic [11:0] OFS_EDGE_SEL  = 12'hfcd;
    localparam logic [11:0] OFS_SHARE_SEL = 12'hfce;
    localparam logic [11:0] OFS_MASTER    = 12'hfcf;
    localparam int          MASTER_BIT    = 7;
    localparam int          SHARE_BIT     = 6;
    localparam int          SHARED_PIN    = 6;
    localparam logic [7:0]  RST_REG       = 8'h00;
    localparam logic [1:0]  PRIO_OFF      = 2'h0;

    // ********************************************************************
    // Controller register map and fields
    // ********************************************************************
    localparam logic [3:0]  HOFS_CMD      = 4'h0;
    localparam logic [3:0]  HOFS_DEV_ADDR = 4'h1;
    localparam logic [3:0]  HOFS_DEV_WDAT = 4'h2;
    localparam logic [3:0]  HOFS_DEV_RDAT = 4'h3;
    localparam logic [3:0]  HOFS_REQ_INFO = 4'h4;
    localparam logic [3:0]  HOFS_STATUS   = 4'h5;
    localparam logic [3:0]  HOFS_MASK     = 4'h6;
    localparam int          CMD_ENABLE    = 0;
    localparam int          CMD_DISABLE   = 1;
    localparam int          CMD_RETURN    = 2;
    localparam int          CMD_ACK       = 3;
    localparam int          CMD_DEV_WR    = 4;
    localparam int          CMD_DEV_RD    = 5;
    localparam int          CMD_SRC_LSB   = 8;
    localparam int          ST_REQ        = 0;
    localparam int          ST_PIN        = 1;
    localparam int          ST_RDONE      = 2;
    localparam logic [2:0]  RST_EVT       = 3'h0;

endpackage

// file: inc/ipeme_if.sv
// Link between the processor end and the interrupt controller end.
`timescale 1ns/1ps
`default_nettype none
interface ipeme_if;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        instr_enable;
    logic        instr_disable;
    logic        instr_return;
    logic        ack;
    logic [3:0]  ack_src;
    logic        req;
    logic [3:0]  req_src;
    logic [1:0]  req_level;
    logic [7:0]  pin_request;

    modport dev (
        input  addr, wdata, wr, rd, instr_enable, instr_disable, instr_return, ack, ack_src,
        output rdata, req, req_src, req_level, pin_request
    );
    modport cpu (
        output addr, wdata, wr, rd, instr_enable, instr_disable, instr_return, ack, ack_src,
        input  rdata, req, req_src, req_level, pin_request
    );
endinterface
`default_nettype wire

// file: src/ipeme_cpu.sv
// Processor end: turns software commands into link strobes and reports events.
`timescale 1ns/1ps
`default_nettype none
module ipeme_cpu (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Software port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             irq,
    // Device link
    ipeme_if.cpu             bus
);

    // ********************************************************************
    // State
    // ********************************************************************
    logic [11:0] dev_addr, next_dev_addr;
    logic [7:0]  dev_wdat, next_dev_wdat;
    logic [7:0]  dev_rdat, next_dev_rdat;
    logic [2:0]  status, next_status;
    logic [2:0]  mask, next_mask;
    logic [5:0]  strb, next_strb;
    logic        rd_wait, next_rd_wait;
    logic        req_prev, next_req_prev;
    logic        pin_prev, next_pin_prev;
    logic [15:0] next_rdata;
    logic [2:0]  evt;
    logic        cmd;

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        cmd           = wr && (addr == ipeme_pkg::HOFS_CMD);
        next_dev_addr = dev_addr;
        next_dev_wdat = dev_wdat;
        next_mask     = mask;
        if (wr && addr == ipeme_pkg::HOFS_DEV_ADDR) next_dev_addr = wdata[11:0];
        if (wr && addr == ipeme_pkg::HOFS_DEV_WDAT) next_dev_wdat = wdata[7:0];
        if (wr && addr == ipeme_pkg::HOFS_MASK)     next_mask     = wdata[2:0];
        // Strobes: enable, disable, return, ack, device write, device read.
        next_strb = 6'h00;
        if (cmd) begin
            next_strb[0] = wdata[ipeme_pkg::CMD_ENABLE];
            next_strb[1] = wdata[ipeme_pkg::CMD_DISABLE];
            next_strb[2] = wdata[ipeme_pkg::CMD_RETURN];
            next_strb[3] = wdata[ipeme_pkg::CMD_ACK];
            next_strb[4] = wdata[ipeme_pkg::CMD_DEV_WR];
            next_strb[5] = wdata[ipeme_pkg::CMD_DEV_RD] && !wdata[ipeme_pkg::CMD_DEV_WR];
        end
        next_rd_wait  = strb[5];
        next_dev_rdat = rd_wait ? bus.rdata : dev_rdat;
        next_req_prev = bus.req;
        next_pin_prev = |bus.pin_request;
        evt = {rd_wait, next_pin_prev & ~pin_prev, bus.req & ~req_prev};
        // A new event beats the clear of a status read.
        next_status = status;
        if (rd && addr == ipeme_pkg::HOFS_STATUS) next_status = ipeme_pkg::RST_EVT;
        next_status = next_status | evt;
        next_rdata = 16'h0000;
        if (rd) begin
            unique case (addr)
                ipeme_pkg::HOFS_DEV_ADDR: next_rdata = {4'h0, dev_addr};
                ipeme_pkg::HOFS_DEV_WDAT: next_rdata = {8'h00, dev_wdat};
                ipeme_pkg::HOFS_DEV_RDAT: next_rdata = {8'h00, dev_rdat};
                ipeme_pkg::HOFS_REQ_INFO:
                    next_rdata = {bus.pin_request, 1'b0, bus.req, bus.req_level, bus.req_src};
                ipeme_pkg::HOFS_STATUS:   next_rdata = {13'h0000, status};
                ipeme_pkg::HOFS_MASK:     next_rdata = {13'h0000, mask};
                default:                  next_rdata = 16'h0000;
            endcase
        end
    end

    logic [3:0] ack_src, next_ack_src;
    assign next_ack_src = cmd ? wdata[ipeme_pkg::CMD_SRC_LSB +: 4] : ack_src;

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dev_addr <= 12'h000;
            dev_wdat <= 8'h00;
            dev_rdat <= 8'h00;
            status   <= ipeme_pkg::RST_EVT;
            mask     <= ipeme_pkg::RST_EVT;
            strb     <= 6'h00;
            rd_wait  <= 1'b0;
            req_prev <= 1'b0;
            pin_prev <= 1'b0;
            rdata    <= 16'h0000;
            ack_src  <= 4'h0;
        end else begin
            dev_addr <= next_dev_addr;
            dev_wdat <= next_dev_wdat;
            dev_rdat <= next_dev_rdat;
            status   <= next_status;
            mask     <= next_mask;
            strb     <= next_strb;
            rd_wait  <= next_rd_wait;
            req_prev <= next_req_prev;
            pin_prev <= next_pin_prev;
            rdata    <= next_rdata;
            ack_src  <= next_ack_src;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Reserved device bits are always sent as zero by the software image.
    assign bus.addr          = dev_addr;
    assign bus.wdata         = dev_wdat;
    assign bus.instr_enable  = strb[0];
    assign bus.instr_disable = strb[1];
    assign bus.instr_return  = strb[2];
    assign bus.ack           = strb[3];
    assign bus.ack_src       = ack_src;
    assign bus.wr            = strb[4];
    assign bus.rd            = strb[5];
    assign irq               = |(status & mask);

endmodule
`default_nettype wire

// file: test/ipeme_asserts.sv
// Concurrent checks on the link between the processor end and the controller end.
`timescale 1ns/1ps
`default_nettype none
module ipeme_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        arst_n,
    // Processor side of the link
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        instr_enable,
    input wire logic        instr_disable,
    input wire logic        instr_return,
    input wire logic        ack,
    // Controller side of the link
    input wire logic [7:0]  rdata,
    input wire logic        req,
    input wire logic [3:0]  req_src,
    input wire logic [1:0]  req_level,
    input wire logic [7:0]  pin_request
);
    logic master;
    logic next_master;

    // ****************************************************************
    // Expected master enable, clear beating set beating a write
    // ****************************************************************
    always_comb begin
        next_master = master;
        if (wr && addr == ipeme_pkg::OFS_MASTER) begin
            next_master = wdata[ipeme_pkg::MASTER_BIT];
        end
        if (instr_enable || instr_return) begin
            next_master = 1'b1;
        end
        if (instr_disable || ack) begin
            next_master = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            master <= 1'b0;
        end else begin
            master <= next_master;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_prio_rsvd_zero: assert property (rd && (addr == ipeme_pkg::OFS_PRIO_HIGH ||
        addr == ipeme_pkg::OFS_PRIO_LOW) |=> rdata[7:4] == 4'h0)
        else $error("priority register upper bits read nonzero");
    a_share_rsvd_zero: assert property (rd && addr == ipeme_pkg::OFS_SHARE_SEL
        |=> rdata[7] == 1'b0 && rdata[5:0] == 6'h00)
        else $error("shared select reserved bits read nonzero");
    a_ctl_rsvd_zero: assert property (rd && addr == ipeme_pkg::OFS_MASTER
        |=> rdata[6:0] == 7'h00)
        else $error("control register low bits read nonzero");
    a_master_readback: assert property (rd && addr == ipeme_pkg::OFS_MASTER
        |=> rdata[7] == $past(master))
        else $error("master enable read back differs from its causes");
    a_pin_gate: assert property (!master |-> pin_request == 8'h00)
        else $error("pin request shown while master enable is clear");
    a_req_gate: assert property (!master |=> !req)
        else $error("request passed while master enable is clear");
    a_clear_drops: assert property (ack || instr_disable
        |=> pin_request == 8'h00 ##1 !req)
        else $error("request survived an acknowledge or disable");
    a_level_coded: assert property (req |-> req_level != ipeme_pkg::PRIO_OFF)
        else $error("request carries the disabled priority code");
    a_src_portc: assert property (req |-> req_src < 4'h4)
        else $error("request source outside port C bits");

    c_high_level: cover property (req && req_level == 2'h3);
    c_shared_pin: cover property ($rose(pin_request[ipeme_pkg::SHARED_PIN]));
    c_ack_drop: cover property (ack ##2 !req);
endmodule
`default_nettype wire

// file: test/irq_priority_edge_master_enable_bench.sv
// Self-checking bench of the interrupt priority, edge select and master enable block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module irq_priority_edge_master_enable_bench;
    logic        mclk;
    logic        arst_n;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        irq;
    logic [7:0]  pin_in;
    logic        comparator_in;
    logic [3:0]  portc_in;
    int          err_total;
    int          num_checks;
    logic [11:0] ofs [5] = '{12'hfc7, 12'hfc8, 12'hfcd, 12'hfce, 12'hfcf};

    ipeme_if link ();
    ipeme_cpu i_ipeme_cpu (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .bus(link));
    ipeme_device #(.PORTC(4)) i_ipeme_device (.mclk(mclk), .arst_n(arst_n), .bus(link),
        .pin_in(pin_in), .comparator_in(comparator_in), .portc_in(portc_in));
    ipeme_asserts i_ipeme_asserts (.mclk(mclk), .arst_n(arst_n), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .instr_enable(link.instr_enable),
        .instr_disable(link.instr_disable), .instr_return(link.instr_return), .ack(link.ack),
        .rdata(link.rdata), .req(link.req), .req_src(link.req_src),
        .req_level(link.req_level), .pin_request(link.pin_request));

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic cmd(input int b, input logic [3:0] src);
        sw_wr(ipeme_pkg::HOFS_CMD, (16'h0001 << b) | {4'h0, src, 8'h00});
        repeat (3) @(posedge mclk);
    endtask

    task automatic dev_wr(input logic [11:0] a, input logic [7:0] d);
        sw_wr(ipeme_pkg::HOFS_DEV_ADDR, {4'h0, a});
        sw_wr(ipeme_pkg::HOFS_DEV_WDAT, {8'h00, d});
        cmd(ipeme_pkg::CMD_DEV_WR, 4'h0);
    endtask

    task automatic dev_rd(input logic [11:0] a, output logic [7:0] d);
        logic [15:0] v;
        sw_wr(ipeme_pkg::HOFS_DEV_ADDR, {4'h0, a});
        cmd(ipeme_pkg::CMD_DEV_RD, 4'h0);
        sw_rd(ipeme_pkg::HOFS_DEV_RDAT, v);
        d = v[7:0];
    endtask

    task automatic info(output logic [15:0] v);
        repeat (3) @(posedge mclk);
        sw_rd(ipeme_pkg::HOFS_REQ_INFO, v);
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    task automatic t_regs;
        logic [7:0] full [5] = '{8'h0f, 8'h0f, 8'hff, 8'h40, 8'h80};
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            dev_rd(ofs[i], d);
            `CHK(d, ipeme_pkg::RST_REG)
            dev_wr(ofs[i], full[i]);
            dev_rd(ofs[i], d);
            `CHK(d, full[i])
            dev_wr(ofs[i], 8'h00);
            dev_rd(ofs[i], d);
            `CHK(d, 8'h00)
        end
        dev_wr(12'hfc0, 8'hff);
        dev_rd(12'hfc0, d);
        `CHK(d, 8'h00)
        $display("test registers done");
    endtask

    task automatic t_prio;
        logic [15:0] v;
        logic [1:0]  lv;
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 4; c++) begin
                lv = c[1:0];
                dev_wr(ipeme_pkg::OFS_PRIO_HIGH, {7'h00, lv[1]} << i);
                dev_wr(ipeme_pkg::OFS_PRIO_LOW, {7'h00, lv[0]} << i);
                @(posedge mclk);
                portc_in <= 4'h1 << i;
                @(posedge mclk);
                portc_in <= 4'h0;
                info(v);
                `CHK(v[6], 1'b0)
                cmd(ipeme_pkg::CMD_ENABLE, 4'h0);
                info(v);
                `CHK(v[6], lv != 2'h0)
                if (lv != 2'h0) begin
                    `CHK(v[5:0], {lv, i[3:0]})
                end
                cmd(ipeme_pkg::CMD_ACK, i[3:0]);
                info(v);
                `CHK(v[6], 1'b0)
            end
        end
        $display("test priority done");
    endtask

    task automatic t_edge;
        logic [15:0] v;
        dev_wr(ipeme_pkg::OFS_EDGE_SEL, 8'h0f);
        cmd(ipeme_pkg::CMD_RETURN, 4'h0);
        @(posedge mclk);
        pin_in <= 8'hff;
        info(v);
        `CHK(v[15:8], 8'h0f)
        @(posedge mclk);
        pin_in <= 8'h00;
        info(v);
        `CHK(v[15:8], 8'hff)
        cmd(ipeme_pkg::CMD_DISABLE, 4'h0);
        info(v);
        `CHK(v[15:8], 8'h00)
        dev_wr(ipeme_pkg::OFS_MASTER, 8'h80);
        info(v);
        `CHK(v[15:8], 8'hff)
        for (int n = 0; n < 8; n++) begin
            cmd(ipeme_pkg::CMD_ACK, 4'h8 | n[3:0]);
        end
        cmd(ipeme_pkg::CMD_ENABLE, 4'h0);
        info(v);
        `CHK(v[15:8], 8'h00)
        $display("test edge select done");
    endtask

    task automatic t_share;
        logic [15:0] v;
        dev_wr(ipeme_pkg::OFS_EDGE_SEL, 8'h40);
        cmd(ipeme_pkg::CMD_ENABLE, 4'h0);
        @(posedge mclk);
        comparator_in <= 1'b1;
        info(v);
        `CHK(v[15:8], 8'h00)
        // Interrupts are off across the source switch; the edge it makes stays pending.
        cmd(ipeme_pkg::CMD_DISABLE, 4'h0);
        dev_wr(ipeme_pkg::OFS_SHARE_SEL, 8'h40);
        cmd(ipeme_pkg::CMD_ENABLE, 4'h0);
        info(v);
        `CHK(v[15:8], 8'h40)
        cmd(ipeme_pkg::CMD_ACK, 4'he);
        cmd(ipeme_pkg::CMD_ENABLE, 4'h0);
        @(posedge mclk);
        pin_in <= 8'h40;
        info(v);
        `CHK(v[15:8], 8'h00)
        @(posedge mclk);
        comparator_in <= 1'b0;
        @(posedge mclk);
        comparator_in <= 1'b1;
        info(v);
        `CHK(v[15:8], 8'h40)
        cmd(ipeme_pkg::CMD_ACK, 4'he);
        $display("test shared source done");
    endtask

    task automatic t_irq;
        logic [15:0] v;
        logic [7:0]  d;
        sw_wr(ipeme_pkg::HOFS_MASK, 16'h0000);
        sw_rd(ipeme_pkg::HOFS_STATUS, v);
        dev_wr(ipeme_pkg::OFS_PRIO_HIGH, 8'h01);
        dev_wr(ipeme_pkg::OFS_PRIO_LOW, 8'h00);
        cmd(ipeme_pkg::CMD_ENABLE, 4'h0);
        @(posedge mclk);
        portc_in <= 4'h1;
        @(posedge mclk);
        portc_in <= 4'h0;
        repeat (4) @(posedge mclk);
        #1 `CHK(irq, 1'b0)
        sw_wr(ipeme_pkg::HOFS_MASK, 16'h0001);
        #1 `CHK(irq, 1'b1)
        sw_rd(ipeme_pkg::HOFS_STATUS, v);
        `CHK(v, 16'h0001)
        `CHK(irq, 1'b0)
        sw_wr(ipeme_pkg::HOFS_MASK, 16'h0004);
        dev_rd(ipeme_pkg::OFS_MASTER, d);
        `CHK(d, 8'h80)
        `CHK(irq, 1'b1)
        cmd(ipeme_pkg::CMD_ACK, 4'h0);
        dev_rd(ipeme_pkg::OFS_MASTER, d);
        `CHK(d, 8'h00)
        $display("test interrupt output done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, reset, sequence and watchdog
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        err_total = 0;
        num_checks = 0;
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        pin_in = 8'h00;
        comparator_in = 1'b0;
        portc_in = 4'h0;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        t_regs();
        t_prio();
        t_edge();
        t_share();
        t_irq();
        results();
    end

    initial begin
        #200us;
        err_total++;
        results();
    end
endmodule
`default_nettype wire
